/* File: core/scl_pkg.sv */
// Package of shared constants for the SCSI low-level bus control ends
// Summary of operation
// - Three timers, 100 us to over 6.5 s
// - Expiry sets status bit, maskable interrupt
// - Parity accumulator XORs every passing byte
// - Any accumulator write clears it
// - Selection loads responder id into accumulator
// - Option: id goes only to accumulator
// - Bytes pass in order, never reordered
// - Software writes 08 to enter low-level
// - Output control write drives control lines
// - Control one 50 connects; ATN needs connection
// - Data driven during selection, else only on out-phase match
// - Sense: REQ bit 7, phase bits 2:0
// - Sense reads 86, 82, 81, 83 per phase
// - ACK with phase, then phase only
// - Target drops REQ after ACK
// - Target answers selection with BSY
// - Data sense shows live data lines
// - Control zero CC enables parity
// - Software loads id bits before selection
package scl_pkg;
  localparam logic [4:0] SCL_ADR_OUTPUT_DATA_LATCH_OUT = 5'h00;
  localparam logic [4:0] SCL_ADR_OCTL = 5'h01;
  localparam logic [4:0] SCL_ADR_BCTL = 5'h02;
  localparam logic [4:0] SCL_ADR_BDAT = 5'h03;
  localparam logic [4:0] SCL_ADR_CTL0 = 5'h04;
  localparam logic [4:0] SCL_ADR_CTL1 = 5'h05;
  localparam logic [4:0] SCL_ADR_DMAC = 5'h06;
  localparam logic [4:0] SCL_ADR_LPAR = 5'h07;
  localparam logic [4:0] SCL_ADR_FBR = 5'h08;
  localparam logic [4:0] SCL_ADR_IEN = 5'h09;
  localparam logic [4:0] SCL_ADR_IST = 5'h0A;
  localparam logic [4:0] SCL_ADR_TSEL = 5'h0B;
  localparam logic [4:0] SCL_ADR_THS = 5'h0C;
  localparam logic [4:0] SCL_ADR_TGP = 5'h0D;
  localparam logic [4:0] SCL_ADR_OPT = 5'h0E;
  // Control line bit positions, shared by drive and sense
  localparam int SCL_B_IO = 0;
  localparam int SCL_B_CD = 1;
  localparam int SCL_B_MSG = 2;
  localparam int SCL_B_ATN = 3;
  localparam int SCL_B_SEL = 4;
  localparam int SCL_B_BSY = 5;
  localparam int SCL_B_ACK = 6;
  localparam int SCL_B_REQ = 7;
  localparam logic [7:0] SCL_PHASE_MASK = 8'h07;
  localparam logic [7:0] SCL_LOWLEVEL_VAL = 8'h08;
  localparam logic [7:0] SCL_CONNECT_MASK = 8'h10;
  localparam logic [7:0] SCL_DATA_EN_MASK = 8'h40;
  localparam logic [7:0] SCL_PARITY_MASK = 8'h0C;
  localparam int SCL_OPT_FBR_SKIP = 0;
  localparam int SCL_IRQ_SEL = 0;
  localparam int SCL_IRQ_HS = 1;
  localparam int SCL_IRQ_GP = 2;
  localparam logic [7:0] SCL_RESET_BYTE = 8'h00;
  // Timer tick of 100 us at a 50 ns clock
  localparam int SCL_CLK_NS = 50;
  localparam int SCL_TICK_US = 100;
  localparam int SCL_TICK_CYC = SCL_TICK_US * 1000 / SCL_CLK_NS;
  // Timer max above 6.5 s: 16-bit count of ticks
  localparam int SCL_TMR_W = 16;
  localparam int SCL_TGT_DELAY = 4;
endpackage

/* File: core/scl_bus_if.sv */
// Interface carrying the SCSI bus between initiator core and target
`timescale 1ns/1ps
interface scl_bus_if;
  logic [7:0] ini_ctl;
  logic [7:0] ini_ctl_oe;
  logic [7:0] ini_dat;
  logic ini_dat_oe;
  logic ini_dp;
  logic [7:0] tgt_ctl;
  logic [7:0] tgt_dat;
  logic tgt_dat_oe;
  logic tgt_dp;
  modport initiator (
    output ini_ctl, ini_ctl_oe, ini_dat, ini_dat_oe, ini_dp,
    input tgt_ctl, tgt_dat, tgt_dat_oe, tgt_dp
  );
  modport target (
    input ini_ctl, ini_ctl_oe, ini_dat, ini_dat_oe, ini_dp,
    output tgt_ctl, tgt_dat, tgt_dat_oe, tgt_dp
  );
endinterface

/* File: core/scl_initiator.sv */
// Initiator core: Wishbone registers, low-level SCSI drive, timers and parity
`timescale 1ns/1ps
module scl_initiator
  import scl_pkg::*;
#(
  parameter int TICK_CYC = SCL_TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [6:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  scl_bus_if.initiator bus
);
  logic [7:0] out_data, out_ctl, ctl0, ctl1, dmac, lpar, fbr, ien, ist, opt;
  logic [SCL_TMR_W-1:0] tsel_lim, ths_lim, tgp_lim;
  logic [SCL_TMR_W-1:0] tsel_cnt, ths_cnt, tgp_cnt;
  logic [$clog2(TICK_CYC+1)-1:0] pre_cnt;
  logic [7:0] s1_ctl, s2_ctl, s3_ctl, sns_ctl;
  logic [7:0] s1_dat, s2_dat, s3_dat, sns_dat;
  logic sel_wait, sel_gap;
  logic [7:0] prev_ctl;

  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = wb_req && wb_we_i && wb_sel_i[0];
  wire [4:0] reg_idx = wb_adr_i[6:2];
  wire connected = (ctl1 & SCL_CONNECT_MASK) != 8'h00;
  wire data_en = (ctl1 & SCL_DATA_EN_MASK) != 8'h00;
  wire low_level = dmac == SCL_LOWLEVEL_VAL;
  wire par_en = (ctl0 & SCL_PARITY_MASK) == SCL_PARITY_MASK;
  wire tick = pre_cnt == ($clog2(TICK_CYC+1))'(TICK_CYC - 1);
  // Phase match: phase bits written equal phase sensed
  wire phase_ok = (out_ctl & SCL_PHASE_MASK) == (sns_ctl & SCL_PHASE_MASK);
  wire selecting = out_ctl[SCL_B_SEL];
  wire info_phase = sns_ctl[SCL_B_BSY] && !selecting;
  wire ack_edge = out_ctl[SCL_B_ACK] && !prev_ctl[SCL_B_ACK];
  // Own BSY must be seen gone first, else its echo looks like the target's answer
  wire bsy_seen = sel_wait && sel_gap && sns_ctl[SCL_B_BSY] && !out_ctl[SCL_B_BSY];
  wire [7:0] byte_in = bus.ini_dat_oe ? bus.ini_dat : sns_dat;

  // Line drive: in low-level mode SEL, BSY and ACK follow the written register; ATN also needs a connection
  always_comb begin
    bus.ini_ctl = low_level ? out_ctl : 8'h00;
    bus.ini_ctl[SCL_B_ATN] = low_level && connected && out_ctl[SCL_B_ATN];
    bus.ini_ctl[SCL_B_REQ] = 1'b0;
    // Phase lines belong to the target; written phase bits only feed the match
    bus.ini_ctl[SCL_B_MSG:SCL_B_IO] = 3'b000;
    bus.ini_ctl_oe = bus.ini_ctl;
  end
  // Selection drives ids; out phases only on phase match, the target owns in-phases
  wire out_phase = info_phase && phase_ok && !sns_ctl[SCL_B_IO];
  assign bus.ini_dat_oe = low_level && data_en && connected && (selecting || out_phase);
  assign bus.ini_dat = out_data;
  assign bus.ini_dp = par_en ? ~^out_data : 1'b0;

  // Three-stage input capture; second and third must agree
  always_ff @(posedge clk_i) begin
    s1_ctl <= bus.tgt_ctl | bus.ini_ctl;
    s2_ctl <= s1_ctl;
    s3_ctl <= s2_ctl;
    s1_dat <= bus.tgt_dat_oe ? bus.tgt_dat : bus.ini_dat;
    s2_dat <= s1_dat;
    s3_dat <= s2_dat;
    if (s2_ctl == s3_ctl) begin
      sns_ctl <= s3_ctl;
    end
    if (s2_dat == s3_dat) begin
      sns_dat <= s3_dat;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_cnt <= '0;
    end else begin
      pre_cnt <= tick ? '0 : pre_cnt + 1'b1;
    end
  end

  // Timers count 100 us ticks; a zero limit disables a timer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tsel_cnt <= '0;
      ths_cnt <= '0;
      tgp_cnt <= '0;
      ist <= SCL_RESET_BYTE;
    end else begin
      if (!sel_wait || bsy_seen) begin
        tsel_cnt <= '0;
      end else if (tick) begin
        tsel_cnt <= tsel_cnt + 1'b1;
      end
      if (!info_phase || ack_edge) begin
        ths_cnt <= '0;
      end else if (tick) begin
        ths_cnt <= ths_cnt + 1'b1;
      end
      if (wr && reg_idx == SCL_ADR_TGP) begin
        tgp_cnt <= '0;
      end else if (tick && tgp_lim != '0) begin
        tgp_cnt <= (tgp_cnt == tgp_lim) ? '0 : tgp_cnt + 1'b1;
      end
      // Write one to clear; a fresh expiry wins over the clear
      if (wr && reg_idx == SCL_ADR_IST) begin
        ist <= ist & ~wb_dat_i[7:0];
      end
      if (tsel_lim != '0 && tsel_cnt == tsel_lim) begin
        ist[SCL_IRQ_SEL] <= 1'b1;
      end
      if (ths_lim != '0 && ths_cnt == ths_lim) begin
        ist[SCL_IRQ_HS] <= 1'b1;
      end
      if (tgp_lim != '0 && tgp_cnt == tgp_lim && tick) begin
        ist[SCL_IRQ_GP] <= 1'b1;
      end
    end
  end
  assign irq_o = (ist & ien) != 8'h00;

  // Byte capture: accumulator and first byte received
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lpar <= SCL_RESET_BYTE;
      fbr <= SCL_RESET_BYTE;
      sel_wait <= 1'b0;
      sel_gap <= 1'b0;
      prev_ctl <= 8'h00;
    end else begin
      prev_ctl <= out_ctl;
      // Armed on SEL rising only, so one selection loads the id once
      sel_wait <= selecting && !bsy_seen && (sel_wait || !prev_ctl[SCL_B_SEL]);
      sel_gap <= sel_wait && !bsy_seen && (sel_gap || (!sns_ctl[SCL_B_BSY] && !out_ctl[SCL_B_BSY]));
      if (wr && reg_idx == SCL_ADR_LPAR) begin
        lpar <= SCL_RESET_BYTE;
      end else if (bsy_seen) begin
        lpar <= sns_dat;
      end else if (ack_edge && info_phase) begin
        lpar <= lpar ^ byte_in;
      end
      if (wr && reg_idx == SCL_ADR_FBR) begin
        fbr <= wb_dat_i[7:0];
      end else if (bsy_seen && !opt[SCL_OPT_FBR_SKIP]) begin
        fbr <= sns_dat;
      end
    end
  end

  // Software registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_data <= 8'h00;
      out_ctl <= 8'h00;
      ctl0 <= 8'h00;
      ctl1 <= 8'h00;
      dmac <= 8'h00;
      ien <= 8'h00;
      opt <= 8'h00;
      tsel_lim <= '0;
      ths_lim <= '0;
      tgp_lim <= '0;
    end else if (wr) begin
      case (reg_idx)
        SCL_ADR_OUTPUT_DATA_LATCH_OUT: out_data <= wb_dat_i[7:0];
        SCL_ADR_OCTL: out_ctl <= wb_dat_i[7:0];
        SCL_ADR_CTL0: ctl0 <= wb_dat_i[7:0];
        SCL_ADR_CTL1: ctl1 <= wb_dat_i[7:0];
        SCL_ADR_DMAC: dmac <= wb_dat_i[7:0];
        SCL_ADR_IEN: ien <= wb_dat_i[7:0];
        SCL_ADR_OPT: opt <= wb_dat_i[7:0];
        SCL_ADR_TSEL: tsel_lim <= wb_dat_i[SCL_TMR_W-1:0];
        SCL_ADR_THS: ths_lim <= wb_dat_i[SCL_TMR_W-1:0];
        SCL_ADR_TGP: tgp_lim <= wb_dat_i[SCL_TMR_W-1:0];
        default: ;
      endcase
    end
  end

  // Read mux; sense values come straight from the captured lines
  logic [31:0] rd;
  always_comb begin
    rd = 32'h0000_0000;
    case (reg_idx)
      SCL_ADR_OUTPUT_DATA_LATCH_OUT: rd[7:0] = out_data;
      SCL_ADR_OCTL: rd[7:0] = out_ctl;
      SCL_ADR_BCTL: rd[7:0] = sns_ctl;
      SCL_ADR_BDAT: rd[7:0] = sns_dat;
      SCL_ADR_CTL0: rd[7:0] = ctl0;
      SCL_ADR_CTL1: rd[7:0] = ctl1;
      SCL_ADR_DMAC: rd[7:0] = dmac;
      SCL_ADR_LPAR: rd[7:0] = lpar;
      SCL_ADR_FBR: rd[7:0] = fbr;
      SCL_ADR_IEN: rd[7:0] = ien;
      SCL_ADR_IST: rd[7:0] = ist;
      SCL_ADR_TSEL: rd[SCL_TMR_W-1:0] = tsel_lim;
      SCL_ADR_THS: rd[SCL_TMR_W-1:0] = ths_lim;
      SCL_ADR_TGP: rd[SCL_TMR_W-1:0] = tgp_lim;
      SCL_ADR_OPT: rd[7:0] = opt;
      default: rd = 32'h0000_0000;
    endcase
  end

  // One wait-free ack per request; unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= rd;
      end
    end
  end
endmodule

/* File: core/scl_target.sv */
// Target end: answers selection and runs a REQ/ACK byte exchange per phase
`timescale 1ns/1ps
module scl_target
  import scl_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] my_id_i,
  input wire logic [2:0] phase_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic go_i,
  output logic [7:0] rx_byte_o,
  output logic rx_valid_o,
  output logic selected_o,
  output logic busy_o,
  scl_bus_if.target bus
);
  typedef enum {ST_IDLE, ST_SEL, ST_READY, ST_REQ, ST_WAITACKOFF} scl_tgt_state_t;
  scl_tgt_state_t state;
  logic [7:0] s1_ctl, s2_ctl, s3_ctl, ctl;
  logic [7:0] s1_dat, s2_dat, s3_dat, dat;
  logic [7:0] tx_hold;
  logic [2:0] ph;
  logic [2:0] dly;

  wire sel_me = ctl[SCL_B_SEL] && dat[my_id_i];
  wire ack = ctl[SCL_B_ACK];
  wire dir_in = ph[SCL_B_IO];
  // Phase settles for the full delay before REQ; in-phase data is driven from REQ until ACK drops, so the far side sees the phase first
  wire req_on = state == ST_REQ && dly == 3'b000;
  wire drive_on = req_on || state == ST_WAITACKOFF;

  always_ff @(posedge clk_i) begin
    s1_ctl <= bus.ini_ctl;
    s2_ctl <= s1_ctl;
    s3_ctl <= s2_ctl;
    s1_dat <= bus.ini_dat_oe ? bus.ini_dat : 8'h00;
    s2_dat <= s1_dat;
    s3_dat <= s2_dat;
    if (s2_ctl == s3_ctl) begin
      ctl <= s3_ctl;
    end
    if (s2_dat == s3_dat) begin
      dat <= s3_dat;
    end
  end

  always_comb begin
    bus.tgt_ctl = 8'h00;
    bus.tgt_ctl[SCL_B_BSY] = selected_o;
    bus.tgt_ctl[SCL_B_REQ] = req_on;
    bus.tgt_ctl[2:0] = selected_o ? ph : 3'b000;
  end
  assign bus.tgt_dat = tx_hold;
  assign bus.tgt_dat_oe = selected_o && dir_in && drive_on;
  assign bus.tgt_dp = ~^tx_hold;
  assign busy_o = state != ST_READY;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_IDLE;
      selected_o <= 1'b0;
      ph <= 3'b000;
      tx_hold <= 8'h00;
      rx_byte_o <= 8'h00;
      rx_valid_o <= 1'b0;
      dly <= 3'b000;
    end else begin
      rx_valid_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (sel_me && !ctl[SCL_B_BSY]) begin
            state <= ST_SEL;
            dly <= 3'(SCL_TGT_DELAY);
          end
        end
        ST_SEL: begin
          selected_o <= 1'b1;
          tx_hold <= 8'h00;
          if (!ctl[SCL_B_SEL]) begin
            state <= ST_READY;
          end
        end
        ST_READY: begin
          if (go_i) begin
            ph <= phase_i;
            tx_hold <= tx_byte_i;
            dly <= 3'(SCL_TGT_DELAY);
            state <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (dly != 3'b000) begin
            dly <= dly - 1'b1;
          end else if (ack) begin
            rx_byte_o <= dat;
            rx_valid_o <= !dir_in;
            state <= ST_WAITACKOFF;
          end
        end
        ST_WAITACKOFF: begin
          if (!ack) begin
            state <= ST_READY;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule

/* File: tb/scl_checker.sv */
// Checker on the SCSI wire between the two ends
`timescale 1ns/1ps
module scl_checker #(
  parameter int ID = 2
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] ini_ctl,
  input wire logic [7:0] ini_ctl_oe,
  input wire logic [7:0] ini_dat,
  input wire logic ini_dat_oe,
  input wire logic ini_dp,
  input wire logic [7:0] tgt_ctl,
  input wire logic [7:0] tgt_dat,
  input wire logic tgt_dat_oe,
  input wire logic tgt_dp
);
  // Phase seen on the wire, both parties ORed
  wire [2:0] bus_ph = tgt_ctl[2:0] | ini_ctl[2:0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  req_never_a:
    assert property (!ini_ctl[7]) else $error("initiator drove REQ");
  oe_follows_a:
    assert property (ini_ctl_oe == ini_ctl) else $error("line enable differs");
  bsy_answer_a:
    assert property (ini_ctl[4] && !ini_ctl[5] && ini_dat_oe && ini_dat[ID] |-> ##[1:12] tgt_ctl[5])
      else $error("no BSY answer");
  req_drop_a:
    assert property (ini_ctl[6] && tgt_ctl[7] |-> ##[1:12] !tgt_ctl[7]) else $error("REQ held after ACK");
  req_wait_a:
    assert property (ini_ctl[6] |-> !$rose(tgt_ctl[7])) else $error("REQ rose under ACK");
  // Sense lag of a few cycles is allowed before the data must go off
  phase_gate_a:
    assert property ((!ini_ctl[4] && bus_ph[0]) [*6] |-> !ini_dat_oe)
      else $error("data driven in an in-phase");
  tgt_in_only_a:
    assert property (tgt_dat_oe |-> tgt_ctl[0] || $past(tgt_ctl[0])) else $error("target drove out phase");
  parity_gen_a:
    assert property (ini_dat_oe |-> ini_dp == ~^ini_dat) else $error("bad data parity");
  sel_seen_c: cover property (ini_ctl[4] && tgt_ctl[5]);
  ack_seen_c: cover property (ini_ctl[6] && tgt_ctl[7]);
  in_byte_c: cover property (tgt_dat_oe && tgt_ctl[7]);
endmodule

/* File: tb/testbench.sv */
// Bench joining initiator core and target over the SCSI interface
`timescale 1ns/1ps
module testbench;
  import scl_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc = 0;
  logic stb = 0;
  logic we = 0;
  logic go = 0;
  logic [3:0] sel = 4'h1;
  logic [6:0] adr = 0;
  logic [31:0] wdat = 0;
  logic [2:0] ph = 0;
  logic [7:0] tx = 0;
  logic [7:0] rx;
  logic [31:0] dat_o;
  logic ack;
  logic irq;
  int n_errors = 0;
  int n_tests = 0;
  int cyc_cnt = 0;
  scl_bus_if bus();
  // Short tick keeps timer runs brief
  scl_initiator #(.TICK_CYC(4)) i_scl_initiator (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .irq_o(irq), .bus(bus));
  scl_target i_scl_target (.clk_i(clk_i), .rst_i(rst_i), .my_id_i(3'h2), .phase_i(ph), .tx_byte_i(tx),
    .go_i(go), .rx_byte_o(rx), .rx_valid_o(), .selected_o(), .busy_o(), .bus(bus));
  scl_checker i_scl_checker (.clk_i(clk_i), .rst_i(rst_i), .ini_ctl(bus.ini_ctl), .ini_ctl_oe(bus.ini_ctl_oe),
    .ini_dat(bus.ini_dat), .ini_dat_oe(bus.ini_dat_oe), .ini_dp(bus.ini_dp), .tgt_ctl(bus.tgt_ctl),
    .tgt_dat(bus.tgt_dat), .tgt_dat_oe(bus.tgt_dat_oe), .tgt_dp(bus.tgt_dp));
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  task automatic stop_test();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Whole run needs a few hundred cycles
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wb(logic w, logic [4:0] i, logic [7:0] d, output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= {24'h0, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    r = dat_o;
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic wr(logic [4:0] i, logic [7:0] d);
    logic [31:0] r;
    wb(1, i, d, r);
  endtask
  task automatic rd(string name, logic [4:0] i, logic [7:0] exp);
    logic [31:0] r;
    wb(0, i, 8'h00, r);
    chk(name, r[7:0], exp);
  endtask
  // Polling has no count of its own; the run timeout bounds it
  task automatic poll(logic [4:0] i, logic [7:0] m, logic [7:0] v);
    logic [31:0] r;
    do wb(0, i, 8'h00, r); while ((r[7:0] & m) !== v);
  endtask
  task automatic ctl(string name, logic [4:0] i, logic [7:0] d, logic [7:0] exp);
    wr(i, d);
    @(posedge clk_i);
    chk(name, bus.ini_ctl, exp);
  endtask
  task automatic do_reset();
    rst_i <= 1;
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    repeat (5) @(posedge clk_i);
  endtask
  task automatic t_refuse();
    wr(5'h0F, 8'h5A);
    rd("unmapped", 5'h0F, 8'h00);
    sel <= 4'h0;
    wr(SCL_ADR_DMAC, 8'h08);
    sel <= 4'h1;
    rd("sel_off", SCL_ADR_DMAC, 8'h00);
    ctl("not_low", SCL_ADR_OCTL, 8'h20, 8'h00);
  endtask
  task automatic do_select(logic [7:0] o, logic [7:0] f);
    wr(SCL_ADR_CTL0, 8'hCC);
    wr(SCL_ADR_OPT, o);
    wr(SCL_ADR_FBR, f);
    wr(SCL_ADR_OUTPUT_DATA_LATCH_OUT, 8'h84);
    wr(SCL_ADR_DMAC, 8'h08);
    ctl("no_atn", SCL_ADR_OCTL, 8'h28, 8'h20);
    wr(SCL_ADR_CTL1, 8'h50);
    ctl("sel_atn_bsy", SCL_ADR_OCTL, 8'h38, 8'h38);
    ctl("sel_atn", SCL_ADR_OCTL, 8'h18, 8'h18);
    // Our own BSY echo must clear before the target's BSY can be told apart
    poll(SCL_ADR_BCTL, 8'h20, 8'h00);
    poll(SCL_ADR_BCTL, 8'h20, 8'h20);
    ctl("atn_only", SCL_ADR_OCTL, 8'h08, 8'h08);
    rd("lpar_id", SCL_ADR_LPAR, 8'h84);
  endtask
  task automatic t_select();
    do_select(8'h00, 8'h00);
    rd("fbr_id", SCL_ADR_FBR, 8'h84);
    wr(SCL_ADR_LPAR, 8'hFF);
    rd("lpar_clr", SCL_ADR_LPAR, 8'h00);
  endtask
  task automatic t_reselect();
    do_reset();
    rd("rst_dmac", SCL_ADR_DMAC, 8'h00);
    do_select(8'h01, 8'h5A);
    rd("fbr_kept", SCL_ADR_FBR, 8'h5A);
  endtask
  task automatic xfer(logic [2:0] p, logic [7:0] d, output logic [7:0] s);
    logic [7:0] c;
    logic [31:0] r;
    c = {4'h0, p == 3'h6, p};
    ph <= p;
    tx <= d;
    go <= 1;
    poll(SCL_ADR_BCTL, 8'h87, {5'h10, p});
    go <= 0;
    wr(SCL_ADR_OUTPUT_DATA_LATCH_OUT, d);
    wr(SCL_ADR_OCTL, c);
    wb(0, SCL_ADR_BDAT, 8'h00, r);
    s = r[7:0];
    ctl("ack_on", SCL_ADR_OCTL, c | 8'h40, {4'h4, p == 3'h6, 3'h0});
    poll(SCL_ADR_BCTL, 8'h80, 8'h00);
    ctl("ack_off", SCL_ADR_OCTL, {5'h0, p}, 8'h00);
  endtask
  task automatic t_info();
    logic [7:0] s;
    xfer(3'h6, 8'hC0, s);
    chk("msg_out", rx, 8'hC0);
    xfer(3'h2, 8'h12, s);
    chk("command", rx, 8'h12);
    xfer(3'h1, 8'h5A, s);
    chk("data_in", s, 8'h5A);
    xfer(3'h3, 8'h02, s);
    chk("status", s, 8'h02);
    rd("lpar_xor", SCL_ADR_LPAR, 8'h8A);
  endtask
  task automatic t_timer();
    wr(SCL_ADR_IEN, 8'h00);
    wr(SCL_ADR_TGP, 8'h03);
    rd("gp_early", SCL_ADR_IST, 8'h00);
    repeat (40) @(posedge clk_i);
    rd("gp_expired", SCL_ADR_IST, 8'h04);
    chk("irq_masked", {7'h0, irq}, 8'h00);
    wr(SCL_ADR_IEN, 8'h04);
    @(posedge clk_i);
    chk("irq_on", {7'h0, irq}, 8'h01);
    wr(SCL_ADR_TGP, 8'h00);
    wr(SCL_ADR_IST, 8'h04);
    rd("ist_clr", SCL_ADR_IST, 8'h00);
  endtask
  initial begin
    do_reset();
    t_refuse();
    t_select();
    t_info();
    t_timer();
    t_reselect();
    stop_test();
  end
endmodule
